/* File: pkg/addr_gen_pkg.sv */
// Constants and types for the branch and bit address generator
// Notes on behaviour
// - Two-byte indexed address is offset high:low plus index register.
// - Index register is eight bits; long offsets carry the table base.
// - Relative target is program counter plus the displacement byte.
// - Relative target loads the program counter only when the condition holds.
// - Program counter already points past the branch before the add.
// - Displacement is sign-extended to sixteen bits before adding.
// - Relative branch is two bytes; counter advances once per byte fetched.
// - Bit set/clear byte address is the zero-extended byte after the opcode.
// - Bit to set or clear comes from a three-bit opcode field.
// - Bit set/clear is two bytes: opcode then direct address.
// - Write-only direction registers read back as all ones.
// - Test-and-branch reads its byte via zero-page address after the opcode.
// - Test-and-branch displacement is the byte after the direct address.
// - Test-and-branch is three bytes; displacement added after all three.
// - Test-and-branch copies the tested bit into carry.
// - Inherent instructions fetch no operands and form no address.
// - A false branch continues at the already advanced counter.
// - Bit number in bit opcodes ranges zero to seven.
package addr_gen_pkg;

  // ----------------------------------------
  // Modes and widths
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_INHERENT = 3'b000,
    MODE_INDEXED16 = 3'b001,
    MODE_RELATIVE = 3'b010,
    MODE_BIT_SET_CLEAR = 3'b011,
    MODE_BIT_TEST_BRANCH = 3'b100
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPERAND1 = 3'b001,
    ST_OPERAND2 = 3'b010,
    ST_DATA = 3'b011,
    ST_DONE = 3'b100
  } state_e;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] DIR_READ_VALUE = 8'hff;
  localparam int BITNUM_LSB = 1;
  localparam int BITNUM_MSB = 3;
  localparam int CLEAR_SEL_BIT = 0;

  // Sign extension used by both branch modes
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

endpackage

/* File: core/byte_fetch_unit.sv */
// Operand byte fetch with program counter advance
`timescale 1ns/10ps
module byte_fetch_unit (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fetch_req,
  input wire logic load_pc,
  input wire logic [15:0] load_value,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready,
  output logic [15:0] pc,
  output logic [7:0] byte_data,
  output logic byte_valid
);

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] data;
    logic valid;
  } fetch_s;

  fetch_s st_reg;
  fetch_s st_next;

  // ----------------------------------------
  // One fetched byte, one counter step
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    if (load_pc) begin
      st_next.pc = load_value;
    end else if (fetch_req && mem_ready) begin
      st_next.data = mem_rdata;
      st_next.valid = 1'b1;
      st_next.pc = st_reg.pc + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{pc: addr_gen_pkg::PC_RESET, data: 8'h00, valid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pc = st_reg.pc;
  assign byte_data = st_reg.data;
  assign byte_valid = st_reg.valid;

endmodule

/* File: core/branch_bit_address_generator.sv */
// Effective address and branch target generation for the controller core
`timescale 1ns/10ps
module branch_bit_address_generator (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [2:0] mode,
  input wire logic [7:0] index_value,
  input wire logic branch_cond,
  input wire logic carry_in,
  input wire logic dir_write_only,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic [15:0] pc,
  output logic [15:0] effective_address,
  output logic ea_valid,
  output logic [15:0] branch_target,
  output logic branch_taken,
  output logic [2:0] bit_select,
  output logic clear_bit_op,
  output logic set_bit_op,
  output logic carry_out,
  output logic done
);

  typedef struct packed {
    addr_gen_pkg::state_e state;
    addr_gen_pkg::mode_e mode;
    logic [7:0] opcode;
    logic [7:0] index;
    logic cond;
    logic [7:0] op1;
    logic [15:0] ea;
    logic ea_valid;
    logic [15:0] target;
    logic taken;
    logic carry;
    logic done;
  } gen_s;

  gen_s st_reg;
  gen_s st_next;

  logic fetch_req;
  logic load_pc;
  logic [15:0] load_value;
  logic [7:0] fbyte;
  logic fvalid;
  logic data_rd;
  logic [7:0] data_byte;
  logic tested_bit;

  // ----------------------------------------
  // Operand fetch; the counter moves once per byte
  // ----------------------------------------
  byte_fetch_unit i_byte_fetch_unit (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .fetch_req(fetch_req),
    .load_pc(load_pc),
    .load_value(load_value),
    .mem_rdata(mem_rdata),
    .mem_ready(mem_ready),
    .pc(pc),
    .byte_data(fbyte),
    .byte_valid(fvalid)
  );

  function automatic logic [2:0] bit_field(input logic [7:0] op);
    bit_field = op[addr_gen_pkg::BITNUM_MSB:addr_gen_pkg::BITNUM_LSB];
  endfunction

  // Write-only direction registers answer all ones, so a test sees ones
  assign data_byte = dir_write_only ? addr_gen_pkg::DIR_READ_VALUE : mem_rdata;
  assign tested_bit = data_byte[bit_field(st_reg.opcode)];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.ea_valid = 1'b0;
    st_next.taken = 1'b0;
    fetch_req = 1'b0;
    data_rd = 1'b0;
    load_pc = 1'b0;
    load_value = st_reg.target;
    unique case (st_reg.state)
      addr_gen_pkg::ST_IDLE: begin
        if (start) begin
          st_next.opcode = opcode;
          st_next.mode = addr_gen_pkg::mode_e'(mode);
          st_next.index = index_value;
          st_next.cond = branch_cond;
          // Inherent: opcode already counted by the fetch stage, no operands
          if (addr_gen_pkg::mode_e'(mode) == addr_gen_pkg::MODE_INHERENT) begin
            st_next.state = addr_gen_pkg::ST_DONE;
          end else begin
            st_next.state = addr_gen_pkg::ST_OPERAND1;
          end
        end
      end
      addr_gen_pkg::ST_OPERAND1: begin
        fetch_req = 1'b1;
        if (fvalid) begin
          fetch_req = 1'b0;
          st_next.op1 = fbyte;
          unique case (st_reg.mode)
            addr_gen_pkg::MODE_RELATIVE: begin
              // Counter already past both bytes here
              st_next.target = pc + addr_gen_pkg::sext8(fbyte);
              st_next.state = addr_gen_pkg::ST_DONE;
            end
            addr_gen_pkg::MODE_BIT_SET_CLEAR: begin
              st_next.ea = {8'h00, fbyte};
              st_next.ea_valid = 1'b1;
              st_next.state = addr_gen_pkg::ST_DONE;
            end
            addr_gen_pkg::MODE_BIT_TEST_BRANCH: begin
              st_next.ea = {8'h00, fbyte};
              st_next.ea_valid = 1'b1;
              st_next.state = addr_gen_pkg::ST_DATA;
            end
            default: begin
              st_next.state = addr_gen_pkg::ST_OPERAND2;
            end
          endcase
        end
      end
      addr_gen_pkg::ST_DATA: begin
        data_rd = 1'b1;
        if (mem_ready) begin
          st_next.carry = tested_bit;
          st_next.cond = st_reg.opcode[addr_gen_pkg::CLEAR_SEL_BIT] ? ~tested_bit : tested_bit;
          st_next.state = addr_gen_pkg::ST_OPERAND2;
        end
      end
      addr_gen_pkg::ST_OPERAND2: begin
        fetch_req = 1'b1;
        if (fvalid) begin
          fetch_req = 1'b0;
          if (st_reg.mode == addr_gen_pkg::MODE_INDEXED16) begin
            st_next.ea = {st_reg.op1, fbyte} + {8'h00, st_reg.index};
            st_next.ea_valid = 1'b1;
          end else begin
            st_next.target = pc + addr_gen_pkg::sext8(fbyte);
          end
          st_next.state = addr_gen_pkg::ST_DONE;
        end
      end
      addr_gen_pkg::ST_DONE: begin
        st_next.done = 1'b1;
        if (st_reg.mode == addr_gen_pkg::MODE_RELATIVE || st_reg.mode == addr_gen_pkg::MODE_BIT_TEST_BRANCH) begin
          // False branch leaves the advanced counter alone
          load_pc = st_reg.cond;
          st_next.taken = st_reg.cond;
        end
        st_next.state = addr_gen_pkg::ST_IDLE;
      end
      default: begin
        st_next.state = addr_gen_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{state: addr_gen_pkg::ST_IDLE, mode: addr_gen_pkg::MODE_INHERENT, opcode: 8'h00,
                  index: 8'h00, cond: 1'b0, op1: 8'h00, ea: 16'h0000, ea_valid: 1'b0,
                  target: 16'h0000, taken: 1'b0, carry: 1'b0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mem_rd = fetch_req | data_rd;
  assign mem_addr = data_rd ? st_reg.ea : pc;
  assign effective_address = st_reg.ea;
  assign ea_valid = st_reg.ea_valid;
  assign branch_target = st_reg.target;
  assign branch_taken = st_reg.taken;
  assign bit_select = bit_field(st_reg.opcode);
  assign clear_bit_op = (st_reg.mode == addr_gen_pkg::MODE_BIT_SET_CLEAR) &
                        st_reg.opcode[addr_gen_pkg::CLEAR_SEL_BIT];
  assign set_bit_op = (st_reg.mode == addr_gen_pkg::MODE_BIT_SET_CLEAR) &
                      ~st_reg.opcode[addr_gen_pkg::CLEAR_SEL_BIT];
  assign carry_out = st_reg.mode == addr_gen_pkg::MODE_BIT_TEST_BRANCH ? st_reg.carry : carry_in;
  assign done = st_reg.done;

endmodule

/* File: verification/addr_gen_monitor.sv */
// Port checker for the branch and bit address generator
`timescale 1ns/10ps
module addr_gen_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [2:0] mode,
  input wire logic branch_cond,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready,
  input wire logic mem_rd,
  input wire logic [15:0] pc,
  input wire logic [15:0] effective_address,
  input wire logic ea_valid,
  input wire logic [15:0] branch_target,
  input wire logic branch_taken,
  input wire logic [2:0] bit_select,
  input wire logic clear_bit_op,
  input wire logic set_bit_op,
  input wire logic done
);
  logic busy_reg;
  logic cnd_reg;
  logic [2:0] md_reg;
  logic [7:0] op_reg;
  logic [7:0] rd_reg;
  logic [15:0] pc0_reg;
  logic go;
  assign go = start && (!busy_reg || done);
  // Last byte read stands for the operand, so only single-read modes rely on it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      cnd_reg <= 1'b0;
      md_reg <= 3'h0;
      op_reg <= 8'h00;
      rd_reg <= 8'h00;
      pc0_reg <= 16'h0000;
    end else begin
      if (go) begin
        busy_reg <= 1'b1;
        cnd_reg <= branch_cond;
        md_reg <= mode;
        op_reg <= opcode;
        pc0_reg <= pc;
      end else if (done) begin
        busy_reg <= 1'b0;
      end
      if (mem_rd && mem_ready) begin
        rd_reg <= mem_rdata;
      end
    end
  end
  // ----
  // Checks
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_inh_nofetch;
    go && mode == 3'h0 |=> !mem_rd ##1 (done && !mem_rd);
  endproperty
  a_inh_nofetch: assert property (p_inh_nofetch) else $error("inherent op fetched");
  property p_inh_pc;
    go && mode == 3'h0 |-> ##2 pc == $past(pc, 2);
  endproperty
  a_inh_pc: assert property (p_inh_pc) else $error("inherent op moved pc");
  property p_pc_step;
    busy_reg && md_reg inside {3'h1, 3'h2, 3'h3} && mem_rd && mem_ready |=> pc == $past(pc) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  property p_zpage;
    md_reg == 3'h3 && ea_valid |-> effective_address == {8'h00, rd_reg};
  endproperty
  a_zpage: assert property (p_zpage) else $error("bit address wrong");
  property p_bitsel;
    md_reg == 3'h3 && done |-> bit_select == op_reg[3:1] && clear_bit_op == op_reg[0] && set_bit_op == !op_reg[0];
  endproperty
  a_bitsel: assert property (p_bitsel) else $error("bit select wrong");
  property p_taken;
    md_reg == 3'h2 && done |-> branch_taken == cnd_reg;
  endproperty
  a_taken: assert property (p_taken) else $error("branch decision wrong");
  property p_tgt;
    md_reg == 3'h2 && done |-> branch_target == pc0_reg + 16'h0001 + {{8{rd_reg[7]}}, rd_reg};
  endproperty
  a_tgt: assert property (p_tgt) else $error("branch target wrong");
  property p_load;
    branch_taken |-> ##[0:1] pc == branch_target;
  endproperty
  a_load: assert property (p_load) else $error("target not loaded");
  c_rel: cover property (md_reg == 3'h2 && done && branch_taken);
  c_tst: cover property (md_reg == 3'h4 && done && branch_taken);
  c_idx: cover property (md_reg == 3'h1 && ea_valid);
endmodule

/* File: verification/code_memory_model.sv */
// Behavioural memory and I/O space answering the generator's reads
`timescale 1ns/10ps
module code_memory_model #(
  parameter logic [15:0] DIR_ADDR = 16'h0005
) (
  input wire logic sys_clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [15:0] pc,
  input wire logic slow,
  output logic [7:0] mem_rdata,
  output logic mem_ready,
  output logic dir_write_only
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  logic gate = 1'b1;
  // Idle bus shows the inverse of the last byte so a stale sample cannot match
  assign mem_ready = mem_rd && gate;
  assign mem_rdata = mem_ready ? mem[mem_addr] : ~last;
  assign dir_write_only = mem_ready && mem_addr == DIR_ADDR && mem_addr != pc;
  always @(negedge sys_clk) gate <= !slow || 1'($urandom);
  always @(posedge sys_clk) if (mem_ready) last <= mem_rdata;
endmodule

/* File: verification/branch_bit_address_generator_bench.sv */
// Self-checking bench for the branch and bit address generator
`timescale 1ns/10ps
module branch_bit_address_generator_bench;
  localparam logic [15:0] DIR_ADDR = 16'h0005;
  typedef struct packed {
    logic [2:0] m;
    logic o;
    logic tk;
    logic cy;
    logic [2:0] bs;
    logic [15:0] ea;
    logic [15:0] tg;
  } exp_s;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [2:0] mode = 3'h0;
  logic [7:0] index_value = 8'h00;
  logic branch_cond = 1'b0;
  logic carry_in = 1'b0;
  logic slow = 1'b0;
  logic dir_write_only, mem_ready, mem_rd, ea_valid, branch_taken, clear_bit_op, set_bit_op, carry_out, done;
  logic [7:0] mem_rdata;
  logic [15:0] mem_addr, pc, effective_address, branch_target;
  logic [2:0] bit_select;
  logic [15:0] epc = 16'h0000;
  exp_s q[$];
  exp_s w;
  logic ea_seen = 1'b0;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  branch_bit_address_generator i_branch_bit_address_generator (.*);
  code_memory_model #(.DIR_ADDR(DIR_ADDR)) i_code_memory_model (.*);
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // One instruction: operands placed at pc, expectation queued, then driven
  // ----
  task automatic run(input logic [2:0] m, input logic [7:0] op, idx, b1, b2, dat, input logic c);
    exp_s e;
    logic [15:0] nx;
    logic [7:0] dsp;
    int n;
    // Software never aims a bit set/clear at the write-only direction register
    if (m == 3'h3 && b1 == DIR_ADDR[7:0]) b1 = b1 + 8'h01;
    if (m == 3'h4 && epc[15:8] == 8'h00 && b1 - epc[7:0] < 8'h02) b1 = b1 + 8'h02;
    i_code_memory_model.mem[epc] = b1;
    i_code_memory_model.mem[epc + 16'h0001] = b2;
    if (m == 3'h4) i_code_memory_model.mem[{8'h00, b1}] = dat;
    nx = epc + ((m == 3'h1 || m == 3'h4) ? 16'h0002 : {15'h0000, m != 3'h0});
    dsp = m == 3'h4 ? b2 : b1;
    e.m = m;
    e.o = op[0];
    e.cy = m != 3'h4 ? dsp[0] : {8'h00, b1} == DIR_ADDR ? 1'b1 : dat[op[3:1]];
    e.tk = m == 3'h2 ? c : m == 3'h4 && (e.cy ^ op[0]);
    e.bs = op[3:1];
    e.ea = m == 3'h1 ? {b1, b2} + {8'h00, idx} : {8'h00, b1};
    e.tg = nx + {{8{dsp[7]}}, dsp};
    q.push_back(e);
    @(negedge sys_clk);
    start = 1'b1;
    mode = m;
    opcode = op;
    index_value = idx;
    branch_cond = c;
    carry_in = dsp[0];
    @(negedge sys_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    // A missing end of instruction counts as a mismatch and ends the run
    if (done !== 1'b1) begin
      failures++;
      final_report();
    end
    repeat (2) @(negedge sys_clk);
    epc = e.tk ? e.tg : nx;
    check("pc", pc, epc);
  endtask
  always @(negedge sys_clk) begin
    if (ea_valid === 1'b1) ea_seen = 1'b1;
    if (done === 1'b1 && q.size() > 0) begin
      w = q.pop_front();
      check("ea_valid", ea_seen, w.m == 3'h1 || w.m > 3'h2);
      ea_seen = 1'b0;
      check("taken", branch_taken, w.tk);
      if (w.tk) check("target", branch_target, w.tg);
      if (w.m == 3'h1 || w.m > 3'h2) check("ea", effective_address, w.ea);
      check("carry", carry_out, w.cy);
      if (w.m == 3'h3) check("bits", {bit_select, clear_bit_op, set_bit_op}, {w.bs, w.o, !w.o});
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'ha4ae));
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    run(3'h2, 8'h20, 8'h00, 8'h7f, 8'h00, 8'h00, 1'b1);
    run(3'h2, 8'h27, 8'h00, 8'h80, 8'h00, 8'h00, 1'b1);
    run(3'h1, 8'hd6, 8'hff, 8'hff, 8'h01, 8'h00, 1'b0);
    run(3'h4, 8'h0e, 8'h00, DIR_ADDR[7:0], 8'hfe, 8'h00, 1'b0);
    // Runs with i above 40 stall the memory at random to stretch some fetches
    for (int i = 0; i < 80; i++) begin
      slow = i > 40;
      run(3'(i % 5), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
    end
    final_report();
  end
endmodule
bind branch_bit_address_generator addr_gen_monitor i_addr_gen_monitor (.*);
